// ==== src/dsq_pkg.sv ====
package dsq_pkg;
   localparam logic [3:0] DSQ_OFS_VALUE = 4'h6;
   localparam logic [3:0] DSQ_OFS_COUNT = 4'h7;
   localparam logic [3:0] DSQ_OFS_CTRL = 4'h5;
   localparam logic [3:0] DSQ_OFS_ERRC = 4'h4;
   localparam logic [3:0] DSQ_OFS_GO = 4'h8;
   localparam logic [3:0] DSQ_OFS_STATUS = 4'h9;
   localparam int DSQ_BIT_BUF = 7;
   localparam int DSQ_BIT_VERIFY_ONLY_SEL = 6;
   localparam int DSQ_BIT_LAST = 5;
   localparam int DSQ_BIT_ID = 4;
   localparam int DSQ_BIT_CHK = 3;
   localparam int DSQ_BIT_WDM = 7;
   localparam int DSQ_BIT_WHM = 6;
   localparam int DSQ_BIT_WIX = 5;
   localparam int DSQ_BIT_WSM = 4;
   localparam int DSQ_BIT_STOP = 0;
   localparam int DSQ_BIT_VSEL = 7;
   localparam int DSQ_BIT_CSEL = 6;
   localparam int DSQ_BIT_FAIL = 3;
   localparam int DSQ_BIT_RTY = 2;
   localparam int DSQ_BIT_DAC = 1;
   localparam logic [4:0] DSQ_SYNC_BITS = 5'h10;
   localparam logic [2:0] DSQ_BYTE_BITS = 3'h7;
   localparam logic [7:0] DSQ_RESET_BYTE = 8'h00;
   typedef enum logic [5:0] {
      DSQ_IDLE = 6'h01,
      DSQ_XFER = 6'h02,
      DSQ_WMARK = 6'h04,
      DSQ_WSYNC = 6'h08,
      DSQ_WPULSE = 6'h10,
      DSQ_DONE = 6'h20
   } dsq_state_t;
endpackage : dsq_pkg

// ==== src/dsq_if.sv ====
`timescale 1ns/100ps
interface dsq_if;
   logic [7:0] value_byte;
   logic [7:0] count_byte;
   logic value_select;
   logic count_select;
   logic buffer_transfer_sel;
   logic verify_only_sel;
   logic last_sel;
   logic id_sel;
   logic checksum_field_sel;
   logic literal_sel;
   logic wait_data_mark;
   logic wait_header_mark;
   logic wait_index_pulse;
   logic wait_sector_pulse;
   logic stop_sel;
   logic [7:0] field_length_minus_one;
   logic [6:0] mark_timeout;
   modport dec (input value_byte, count_byte, value_select, count_select,
      output buffer_transfer_sel, verify_only_sel, last_sel, id_sel, checksum_field_sel, literal_sel,
      wait_data_mark, wait_header_mark, wait_index_pulse, wait_sector_pulse, stop_sel,
      field_length_minus_one, mark_timeout);
   modport use_side (output value_byte, count_byte, value_select, count_select,
      input buffer_transfer_sel, verify_only_sel, last_sel, id_sel, checksum_field_sel, literal_sel,
      wait_data_mark, wait_header_mark, wait_index_pulse, wait_sector_pulse, stop_sel,
      field_length_minus_one, mark_timeout);
endinterface : dsq_if

// ==== src/dsq_field_dec.sv ====
`timescale 1ns/100ps
module dsq_field_dec (
   dsq_if.dec d
);
   import dsq_pkg::*;
   always_comb begin
      d.literal_sel = !d.value_select;
      d.buffer_transfer_sel = d.value_select & d.value_byte[DSQ_BIT_BUF];
      d.verify_only_sel = d.value_select & d.value_byte[DSQ_BIT_VERIFY_ONLY_SEL];
      d.last_sel = d.value_select & d.value_byte[DSQ_BIT_LAST];
      d.id_sel = d.value_select & d.value_byte[DSQ_BIT_ID];
      d.checksum_field_sel = d.value_select & d.value_byte[DSQ_BIT_CHK];
      d.wait_data_mark = d.count_select & d.count_byte[DSQ_BIT_WDM];
      // low bits of a data mark wait are its timeout, not further conditions
      d.wait_header_mark = d.count_select & !d.count_byte[DSQ_BIT_WDM] & d.count_byte[DSQ_BIT_WHM];
      d.wait_index_pulse = d.count_select & !d.count_byte[DSQ_BIT_WDM] & d.count_byte[DSQ_BIT_WIX];
      d.wait_sector_pulse = d.count_select & !d.count_byte[DSQ_BIT_WDM] & d.count_byte[DSQ_BIT_WSM];
      d.stop_sel = d.count_select & !d.count_byte[DSQ_BIT_WDM] & d.count_byte[DSQ_BIT_STOP];
      d.field_length_minus_one = d.count_byte;
      d.mark_timeout = d.count_byte[6:0];
   end
endmodule : dsq_field_dec

// ==== src/dsq_seq_decode.sv ====
`timescale 1ns/100ps
module dsq_seq_decode (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic serial_read_data,
   input wire logic mark_detect_in,
   input wire logic index_in,
   input wire logic sector_in,
   input wire logic bit_tick,
   input wire logic checksum_bad,
   input wire logic compare_bad,
   input wire logic parity_bad,
   input wire logic [7:0] buffer_rdata,
   input wire logic [7:0] id_write_byte,
   input wire logic checksum_out_bit,
   output logic serial_write_data,
   output logic write_mode,
   output logic buffer_xfer,
   output logic id_xfer,
   output logic checksum_phase,
   output logic data_checksum_sel,
   output logic checksum_run,
   output logic last_segment,
   output logic sector_counter_dec,
   output logic id_counter_inc,
   output logic retry_req,
   output logic busy,
   output logic instr_done
);
   import dsq_pkg::*;

   dsq_if dif ();
   dsq_field_dec u_dec (.d(dif.dec));

   logic [7:0] value_ff;
   logic [7:0] count_ff;
   logic [7:0] ctrl_ff;
   logic [3:0] errc_ff;
   logic write_ff;
   dsq_state_t state_ff;
   logic [7:0] bytecnt_ff;
   logic [2:0] bitcnt_ff;
   logic [4:0] synccnt_ff;
   logic [7:0] shreg_ff;
   logic [7:0] txreg_ff;
   logic sync_err_ff;
   logic chk_err_ff;
   logic xfer_prev_ff;
   logic checksum_run_ff;
   logic [1:0] mk_s_ff;
   logic [1:0] ix_s_ff;
   logic [1:0] sc_s_ff;
   logic [1:0] rd_s_ff;
   logic ix_prev_ff;
   logic sc_prev_ff;
   logic retry_ff;
   logic done_ff;
   logic go;
   logic mark_s;
   logic index_rise;
   logic sector_rise;
   logic byte_end;
   logic [7:0] shifted;
   logic fail_en;
   logic retry_en;
   logic xfer_sel;
   logic any_err;

   assign dif.value_byte = value_ff;
   assign dif.count_byte = count_ff;
   assign dif.value_select = ctrl_ff[DSQ_BIT_VSEL];
   assign dif.count_select = ctrl_ff[DSQ_BIT_CSEL];

   // pin inputs pass two flops before use
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mk_s_ff <= 2'h0;
         ix_s_ff <= 2'h0;
         sc_s_ff <= 2'h0;
         rd_s_ff <= 2'h0;
         ix_prev_ff <= 1'b0;
         sc_prev_ff <= 1'b0;
      end else begin
         mk_s_ff <= {mk_s_ff[0], mark_detect_in};
         ix_s_ff <= {ix_s_ff[0], index_in};
         sc_s_ff <= {sc_s_ff[0], sector_in};
         rd_s_ff <= {rd_s_ff[0], serial_read_data};
         ix_prev_ff <= ix_s_ff[1];
         sc_prev_ff <= sc_s_ff[1];
      end
   end
   assign mark_s = mk_s_ff[1];
   assign index_rise = ix_s_ff[1] & !ix_prev_ff;
   assign sector_rise = sc_s_ff[1] & !sc_prev_ff;

   assign go = reg_wr && reg_addr == DSQ_OFS_GO;
   assign fail_en = errc_ff[DSQ_BIT_FAIL];
   assign retry_en = errc_ff[DSQ_BIT_RTY];
   assign xfer_sel = dif.buffer_transfer_sel | dif.verify_only_sel;
   assign any_err = checksum_bad | compare_bad | parity_bad;
   assign byte_end = bit_tick && bitcnt_ff == 3'h0;
   assign shifted = {shreg_ff[6:0], rd_s_ff[1]};

   // instruction image written by software
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         value_ff <= DSQ_RESET_BYTE;
         count_ff <= DSQ_RESET_BYTE;
         ctrl_ff <= DSQ_RESET_BYTE;
         errc_ff <= 4'h0;
         write_ff <= 1'b0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            DSQ_OFS_VALUE: value_ff <= reg_wdata;
            DSQ_OFS_COUNT: count_ff <= reg_wdata;
            DSQ_OFS_CTRL: ctrl_ff <= reg_wdata;
            DSQ_OFS_ERRC: errc_ff <= reg_wdata[3:0];
            DSQ_OFS_GO: write_ff <= reg_wdata[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            DSQ_OFS_VALUE: reg_rdata <= value_ff;
            DSQ_OFS_COUNT: reg_rdata <= count_ff;
            DSQ_OFS_CTRL: reg_rdata <= ctrl_ff;
            DSQ_OFS_ERRC: reg_rdata <= {4'h0, errc_ff};
            DSQ_OFS_STATUS: reg_rdata <= {2'h0, state_ff};
            DSQ_OFS_GO: reg_rdata <= {4'h0, retry_ff, chk_err_ff, sync_err_ff, busy};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // sequencer for one instruction
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_ff <= DSQ_IDLE;
         bytecnt_ff <= 8'h00;
         bitcnt_ff <= 3'h0;
         synccnt_ff <= 5'h00;
      end else begin
         unique case (state_ff)
            DSQ_IDLE: if (go) begin
               bitcnt_ff <= DSQ_BYTE_BITS;
               synccnt_ff <= DSQ_SYNC_BITS;
               bytecnt_ff <= {1'b0, dif.mark_timeout};
               if (dif.stop_sel) state_ff <= DSQ_IDLE;
               else if (!dif.count_select) begin
                  bytecnt_ff <= dif.field_length_minus_one;
                  state_ff <= DSQ_XFER;
               end else if (dif.wait_data_mark || dif.wait_header_mark) state_ff <= DSQ_WMARK;
               else if (dif.wait_index_pulse || dif.wait_sector_pulse) state_ff <= DSQ_WPULSE;
               else state_ff <= DSQ_DONE;
            end
            DSQ_XFER: if (bit_tick) begin
               bitcnt_ff <= bitcnt_ff - 3'h1;
               if (byte_end) begin
                  bitcnt_ff <= DSQ_BYTE_BITS;
                  bytecnt_ff <= bytecnt_ff - 8'h01;
                  // error halt ends the instruction early
                  if (bytecnt_ff == 8'h00 || (fail_en && any_err)) state_ff <= DSQ_DONE;
               end
            end
            DSQ_WMARK: begin
               if (mark_s) state_ff <= DSQ_WSYNC;
               else if (byte_end && dif.wait_data_mark) begin
                  if (bytecnt_ff == 8'h00) state_ff <= DSQ_DONE;
                  bytecnt_ff <= bytecnt_ff - 8'h01;
               end
               if (bit_tick) bitcnt_ff <= bitcnt_ff - 3'h1;
            end
            DSQ_WSYNC: if (bit_tick && mark_s) begin
               synccnt_ff <= synccnt_ff - 5'h01;
               if (shifted == value_ff) state_ff <= DSQ_DONE;
               else if (synccnt_ff == 5'h01) state_ff <= DSQ_DONE;
            end
            DSQ_WPULSE: begin
               // no timeout: go is ignored outside idle, so only reset kills the wait
               if ((dif.wait_index_pulse && index_rise) ||
                   (dif.wait_sector_pulse && sector_rise)) state_ff <= DSQ_DONE;
            end
            DSQ_DONE: state_ff <= DSQ_IDLE;
            default: state_ff <= DSQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         shreg_ff <= 8'h00;
      end else if (bit_tick) begin
         shreg_ff <= shifted;
      end
   end

   // sync error and retry; errors clear on new go, set wins within a cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync_err_ff <= 1'b0;
         retry_ff <= 1'b0;
         chk_err_ff <= 1'b0;
      end else begin
         if (go) begin
            sync_err_ff <= 1'b0;
            retry_ff <= 1'b0;
            chk_err_ff <= 1'b0;
         end
         if (state_ff == DSQ_WMARK && !mark_s && byte_end && dif.wait_data_mark && bytecnt_ff == 8'h00) begin
            sync_err_ff <= 1'b1;
            retry_ff <= retry_en && !fail_en;
         end
         if (state_ff == DSQ_WSYNC && bit_tick && mark_s && shifted != value_ff && synccnt_ff == 5'h01) begin
            sync_err_ff <= 1'b1;
            // header mark failure only retries
            retry_ff <= dif.wait_header_mark ? retry_en : (retry_en && !fail_en);
         end
         if (state_ff == DSQ_XFER && any_err) chk_err_ff <= 1'b1;
      end
   end

   // checksum runs from sync match until a checksum instruction ends or a stop is issued
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         checksum_run_ff <= 1'b0;
      end else if (state_ff == DSQ_WSYNC && bit_tick && mark_s && shifted == value_ff) begin
         checksum_run_ff <= 1'b1;
      end else if (state_ff == DSQ_DONE && dif.checksum_field_sel) begin
         checksum_run_ff <= 1'b0;
      end else if (state_ff == DSQ_IDLE && go && dif.stop_sel) begin
         checksum_run_ff <= 1'b0;
      end
   end

   // leading edge of buffer or verify select pulses counters
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         xfer_prev_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         xfer_prev_ff <= (state_ff == DSQ_XFER) && xfer_sel;
         done_ff <= state_ff == DSQ_DONE;
      end
   end

   // serial write byte: literal, ID register, or buffer
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         txreg_ff <= 8'h00;
         serial_write_data <= 1'b0;
      end else begin
         if (state_ff != DSQ_XFER || !write_ff) begin
            serial_write_data <= 1'b0;
         end else if (dif.checksum_field_sel) begin
            serial_write_data <= checksum_out_bit;
         end else if (bit_tick) begin
            serial_write_data <= txreg_ff[bitcnt_ff];
         end
         if (state_ff != DSQ_XFER || byte_end) begin
            if (dif.literal_sel) txreg_ff <= value_ff;
            else if (dif.id_sel) txreg_ff <= id_write_byte;
            else if (dif.buffer_transfer_sel) txreg_ff <= buffer_rdata;
            else txreg_ff <= 8'h00;
         end
      end
   end

   assign busy = state_ff != DSQ_IDLE;
   assign write_mode = write_ff & busy;
   assign buffer_xfer = state_ff == DSQ_XFER && dif.buffer_transfer_sel;
   assign id_xfer = state_ff == DSQ_XFER && dif.id_sel;
   assign checksum_phase = state_ff == DSQ_XFER && dif.checksum_field_sel;
   assign data_checksum_sel = errc_ff[DSQ_BIT_DAC];
   assign checksum_run = checksum_run_ff;
   assign last_segment = busy && dif.last_sel && xfer_sel;
   assign sector_counter_dec = (state_ff == DSQ_XFER) && xfer_sel && !xfer_prev_ff;
   assign id_counter_inc = sector_counter_dec;
   assign retry_req = retry_ff;
   assign instr_done = done_ff;

   property p_stop;
      @(posedge clk_sys) disable iff (!resetn)
         (state_ff == DSQ_IDLE && go && dif.stop_sel) |=> !busy && !checksum_run_ff;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not idle");
   property p_len;
      @(posedge clk_sys) disable iff (!resetn)
         (state_ff == DSQ_IDLE && go && !dif.count_select && !dif.stop_sel) |=> bytecnt_ff == $past(count_ff);
   endproperty
   a_len: assert property (p_len) else $error("length not loaded");
   property p_pulse;
      @(posedge clk_sys) disable iff (!resetn) sector_counter_dec |=> !sector_counter_dec;
   endproperty
   a_pulse: assert property (p_pulse) else $error("counter pulse too long");
   property p_wait;
      @(posedge clk_sys) disable iff (!resetn)
         (state_ff == DSQ_WPULSE && !index_rise && !sector_rise) |=> state_ff == DSQ_WPULSE;
   endproperty
   a_wait: assert property (p_wait) else $error("pulse wait left early");
   property p_sync;
      @(posedge clk_sys) disable iff (!resetn) $rose(sync_err_ff) |-> $past(state_ff) != DSQ_XFER;
   endproperty
   a_sync: assert property (p_sync) else $error("sync error outside wait");
   property p_chk;
      @(posedge clk_sys) disable iff (!resetn) $rose(checksum_run_ff) |-> $past(state_ff) == DSQ_WSYNC;
   endproperty
   a_chk: assert property (p_chk) else $error("checksum start off sync");
   property p_done;
      @(posedge clk_sys) disable iff (!resetn) state_ff == DSQ_DONE |=> state_ff == DSQ_IDLE ##0 instr_done;
   endproperty
   a_done: assert property (p_done) else $error("done not reported");
   property p_last;
      @(posedge clk_sys) disable iff (!resetn) last_segment |-> ctrl_ff[DSQ_BIT_VSEL] && value_ff[DSQ_BIT_LAST] &&
         (value_ff[DSQ_BIT_BUF] || value_ff[DSQ_BIT_VERIFY_ONLY_SEL]);
   endproperty
   a_last: assert property (p_last) else $error("last without transfer");
   c_xfer: cover property (@(posedge clk_sys) state_ff == DSQ_XFER ##1 state_ff == DSQ_DONE);
   c_sync: cover property (@(posedge clk_sys) $rose(checksum_run_ff));
   c_serr: cover property (@(posedge clk_sys) $rose(sync_err_ff));
endmodule : dsq_seq_decode

// ==== dv/dsq_drive_model.sv ====
`timescale 1ns/100ps
module dsq_drive_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic mark_en,
   input wire logic pat_en,
   input wire logic [7:0] pat_byte,
   input wire logic idx_req,
   input wire logic sec_req,
   output logic serial_read_data,
   output logic mark_detect_in,
   output logic index_in,
   output logic sector_in,
   output logic bit_tick,
   output logic [7:0] buffer_rdata,
   output logic [7:0] id_write_byte,
   output logic checksum_out_bit
);
   logic [2:0] ph_ff;
   logic [2:0] bit_ff;
   logic [4:0] idx_ff;
   logic [4:0] sec_ff;
   assign bit_tick = (ph_ff == 3'h7);
   assign mark_detect_in = mark_en;
   assign index_in = (idx_ff != 5'h00);
   assign sector_in = (sec_ff != 5'h00);
   assign id_write_byte = 8'h5a;
   assign checksum_out_bit = bit_ff[0];
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ph_ff <= 3'h0;
         bit_ff <= 3'h0;
         idx_ff <= 5'h00;
         sec_ff <= 5'h00;
         serial_read_data <= 1'b0;
         buffer_rdata <= 8'h00;
      end else begin
         ph_ff <= ph_ff + 3'h1;
         // pulses long enough to survive the input synchronisers
         idx_ff <= idx_req ? 5'h10 : ((idx_ff != 5'h00) ? idx_ff - 5'h01 : 5'h00);
         sec_ff <= sec_req ? 5'h10 : ((sec_ff != 5'h00) ? sec_ff - 5'h01 : 5'h00);
         if (bit_tick) begin
            bit_ff <= bit_ff + 3'h1;
            // idle line toggles so no stale level passes for a pattern
            serial_read_data <= pat_en ? pat_byte[3'h7 - bit_ff] : ~serial_read_data;
            if (bit_ff == 3'h7) begin
               buffer_rdata <= buffer_rdata + 8'h01;
            end
         end
      end
   end
endmodule : dsq_drive_model

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`define CK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
   import dsq_pkg::*;
   typedef struct {logic [7:0] c; logic [7:0] e; logic [7:0] v; logic [7:0] n; logic d; int t; logic [7:0] s;} dsq_row_t;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] errs = 3'h0;
   logic mark_en = 1'b0;
   logic pat_en = 1'b0;
   logic [7:0] pat_byte = 8'h00;
   logic idx_req = 1'b0;
   logic sec_req = 1'b0;
   logic [7:0] reg_rdata, brd, idw, seen, rd_v, sw_q;
   logic srd, mdi, idx, sec, btk, cob, swd, wm, bx, ix, cph, dcs, crun, lseg, sdec, iinc, retry_enable, busy, done, cr_seen;
   logic btk_q;
   int bad_count = 0;
   int n_checks = 0;
   int n_sd, n_dn, n_rt, n_tk, k;
   dsq_row_t rows [10] = '{
      '{8'h00, 8'h00, 8'h80, 8'h00, 1'b0, 8, 8'h00},
      '{8'h00, 8'h00, 8'h4e, 8'h03, 1'b1, 32, 8'h80},
      '{8'h80, 8'h00, 8'h80, 8'h01, 1'b0, 16, 8'h05},
      '{8'h80, 8'h02, 8'h40, 8'h00, 1'b0, 8, 8'h41},
      '{8'h80, 8'h02, 8'ha0, 8'h01, 1'b1, 16, 8'hcd},
      '{8'h80, 8'h00, 8'h10, 8'h03, 1'b0, 32, 8'h10},
      '{8'h80, 8'h02, 8'h08, 8'h01, 1'b1, 16, 8'he0},
      '{8'h80, 8'h00, 8'h08, 8'h01, 1'b0, 16, 8'h20},
      '{8'h80, 8'h02, 8'h80, 8'hff, 1'b0, 2048, 8'h45},
      '{8'hc0, 8'h00, 8'h80, 8'h01, 1'b1, -1, 8'h00}};
   dsq_seq_decode i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_read_data(srd), .mark_detect_in(mdi),
      .index_in(idx), .sector_in(sec), .bit_tick(btk), .checksum_bad(errs[0]), .compare_bad(errs[1]),
      .parity_bad(errs[2]), .buffer_rdata(brd), .id_write_byte(idw), .checksum_out_bit(cob),
      .serial_write_data(swd), .write_mode(wm), .buffer_xfer(bx), .id_xfer(ix), .checksum_phase(cph),
      .data_checksum_sel(dcs), .checksum_run(crun), .last_segment(lseg), .sector_counter_dec(sdec),
      .id_counter_inc(iinc), .retry_req(retry_enable), .busy(busy), .instr_done(done));
   dsq_drive_model i_drive (.clk_sys(clk_sys), .resetn(resetn), .mark_en(mark_en), .pat_en(pat_en),
      .pat_byte(pat_byte), .idx_req(idx_req), .sec_req(sec_req), .serial_read_data(srd), .mark_detect_in(mdi),
      .index_in(idx), .sector_in(sec), .bit_tick(btk), .buffer_rdata(brd), .id_write_byte(idw),
      .checksum_out_bit(cob));
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (busy === 1'b1) begin
         seen <= seen | {wm, dcs, cph, ix, lseg, bx, 1'b0, iinc};
      end
      if (busy === 1'b1 && btk) begin
         n_tk <= n_tk + 1;
      end
      if (crun === 1'b1) begin
         cr_seen <= 1'b1;
      end
      // serial bit of a tick is settled one edge later
      btk_q <= btk;
      if (btk_q === 1'b1 && wm === 1'b1) begin
         sw_q <= {sw_q[6:0], swd};
      end
      n_sd <= n_sd + (sdec === 1'b1);
      n_dn <= n_dn + (done === 1'b1);
      n_rt <= n_rt + (retry_enable === 1'b1);
   end
   task wrap_up;
      if (bad_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask : rd
   task rst;
      @(posedge clk_sys);
      resetn <= 1'b0;
      mark_en <= 1'b0;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
   endtask : rst
   task go(input dsq_row_t r);
      wr(DSQ_OFS_CTRL, r.c);
      wr(DSQ_OFS_ERRC, r.e);
      wr(DSQ_OFS_VALUE, r.v);
      wr(DSQ_OFS_COUNT, r.n);
      rd(DSQ_OFS_VALUE);
      `CK("value_window", r.v, rd_v)
      rd(DSQ_OFS_COUNT);
      `CK("count_window", r.n, rd_v)
      n_sd = 0;
      n_dn = 0;
      n_rt = 0;
      n_tk = 0;
      seen = 8'h00;
      cr_seen = 1'b0;
      wr(DSQ_OFS_GO, {7'h00, r.d});
   endtask : go
   task wait_idle(input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge clk_sys);
         #1;
         if (busy === 1'b0) break;
      end
      if (i == lim) begin
         bad_count++;
         wrap_up();
      end
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : wait_idle
   initial begin
      rst();
      rd(DSQ_OFS_STATUS);
      `CK("status", {2'b00, DSQ_IDLE}, rd_v)
      rd(4'hf);
      `CK("unmapped", 8'h00, rd_v)
      for (k = 0; k < 10; k++) begin
         go(rows[k]);
         wait_idle(20000);
         `CK("sdec", rows[k].s[0], n_sd)
         if (rows[k].d && !rows[k].c[7]) `CK("serial_out", rows[k].v, sw_q)
         if (rows[k].t >= 0) begin
            `CK("ticks", rows[k].t, n_tk)
            `CK("seen", rows[k].s, seen)
            `CK("done", 1, n_dn)
         end
      end
      for (k = 0; k < 2; k++) begin
         go('{8'h40, 8'h00, 8'h00, (k == 1) ? 8'h10 : 8'h20, 1'b0, 0, 8'h00});
         repeat (400) @(posedge clk_sys);
         #1 `CK("wait_held", 1'b1, busy)
         @(posedge clk_sys);
         idx_req <= (k == 0);
         sec_req <= (k == 1);
         @(posedge clk_sys);
         idx_req <= 1'b0;
         sec_req <= 1'b0;
         wait_idle(100);
         `CK("pulse_done", 1, n_dn)
      end
      pat_en <= 1'b1;
      pat_byte <= 8'ha1;
      for (k = 0; k < 2; k++) begin
         // checksum run only falls on reset, a checksum instruction or a stop instruction
         rst();
         go('{8'h40, 8'h02, 8'ha1, (k == 1) ? 8'h40 : 8'h85, 1'b0, 0, 8'h00});
         repeat (20) @(posedge clk_sys);
         mark_en <= 1'b1;
         wait_idle(600);
         mark_en <= 1'b0;
         `CK("mark_done", 1, n_dn)
         `CK("crun", 1'b1, cr_seen)
      end
      pat_en <= 1'b0;
      for (k = 0; k < 3; k++) begin
         rst();
         go('{8'h40, (k == 1) ? 8'h08 : 8'h04, 8'ha1, (k == 2) ? 8'h40 : 8'h85, 1'b0, 0, 8'h00});
         repeat (20) @(posedge clk_sys);
         mark_en <= 1'b1;
         repeat (200) @(posedge clk_sys);
         mark_en <= 1'b0;
         #1 `CK("retry", (k != 1), (n_rt != 0))
         if (k == 1) begin
            rd(DSQ_OFS_GO);
            `CK("sync_flag", 1'b1, rd_v[1])
         end
      end
      // reset is the host's only abort of a wait
      rst();
      go('{8'h40, 8'h08, 8'ha1, 8'h82, 1'b0, 0, 8'h00});
      wait_idle(400);
      rd(DSQ_OFS_GO);
      `CK("timeout_flag", 1'b1, rd_v[1])
      `CK("timeout_ticks", 24, n_tk)
      for (k = 0; k < 3; k++) begin
         go('{8'h80, 8'h0a, 8'h80, 8'h0f, 1'b1, 0, 8'h00});
         repeat (100) @(posedge clk_sys);
         errs <= 3'h1 << k;
         wait_idle(1200);
         errs <= 3'h0;
         `CK("halted", 1'b1, (n_tk < 128))
         if (k == 0) begin
            rd(DSQ_OFS_GO);
            `CK("chk_flag", 1'b1, rd_v[2])
         end
      end
      wrap_up();
   end
endmodule : tb_top
